// file: rtl/input_filter_interrupt_timer.sv
/*
 * Input conditioning and interrupt logic: debounced inputs, interrupt
 * inputs (direct, counter, quick-response) and an interval timer.
 * Assumes field inputs are asynchronous pins, and that the program core
 * drives the acknowledge and configuration inputs on the system clock.
 */
`include "irq_filter_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module input_filter_interrupt_timer (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Field pins and output words
   input wire logic [`N_IN-1:0] field_in_i,
   input wire logic [`N_OUT-1:0] out_word_i,
   output logic [`N_IN-1:0] io_bit_area_o,
   output logic [`N_OUT-1:0] out_pins_o,
   // Configuration
   input wire logic variant_two_i,
   input wire logic [2:0] filter_sel_i,
   input wire logic [2*`N_CH-1:0] chan_mode_i,
   input wire logic [`CNT_W*`N_CH-1:0] count_set_i,
   // Interrupt requests to the program core
   output logic [`N_CH-1:0] int_req_o,
   input wire logic [`N_CH-1:0] int_ack_i,
   input wire logic [`N_CH-1:0] quick_clr_i,
   // Interval timer
   input wire logic timer_start_i,
   input wire logic timer_stop_i,
   input wire logic timer_mode_i,
   input wire logic [`TMR_W-1:0] timer_period_i,
   input wire logic timer_ack_i,
   output logic timer_int_o,
   output logic timer_running_o
);

   // ============================================================
   // Reset release
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ============================================================
   // Pin synchronisers and edge history
   logic [`N_IN-1:0] in_meta;
   logic [`N_IN-1:0] in_sync;
   logic [`N_IN-1:0] in_prev;

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         in_meta <= '0;
         in_sync <= '0;
         in_prev <= '0;
      end else begin
         in_meta <= field_in_i;
         in_sync <= in_meta;
         in_prev <= in_sync;
      end
   end

   // ============================================================
   // 0.1 ms tick
   tick_if tk ();
   logic [`TICK_CNT_W-1:0] tick_cnt;

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
      end else if (tick_cnt == `TICK_CNT_W'(`TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   assign tk.tick = (tick_cnt == `TICK_CNT_W'(`TICK_CYCLES - 1));
   assign tk.filter_sel = filter_sel_i;

   // ============================================================
   // Debounce filter
   logic [`N_IN-1:0] filt;

   // two-flop sync plus filter delay only
   input_debounce u_debounce (
      .clk(sys_clk_i),
      .rst_n(rst_n),
      .tk(tk),
      .raw(in_sync),
      .filt(filt)
   );

   // ============================================================
   // Interrupt-capable channels
   irq_filter_pkg::chan_mode_e mode [`N_CH];
   logic [`CNT_W-1:0] pulse_cnt [`N_CH];
   logic [`N_CH-1:0] ch_en;
   logic [`N_CH-1:0] rise;
   logic [`N_CH-1:0] hit;
   logic [`N_CH-1:0] quick_latch;

   for (genvar i = 0; i < `N_CH; i++) begin : g_ch
      localparam int B = `CH_BASE_BIT + i;
      logic [`CNT_W-1:0] next_cnt;

      assign mode[i] = irq_filter_pkg::chan_mode_e'(chan_mode_i[2*i +: 2]);
      assign ch_en[i] = (i < `N_CH_SMALL) || !variant_two_i;
      // raw synced edge, bypassing the filter
      assign rise[i] = in_sync[B] && !in_prev[B];
      assign next_cnt = pulse_cnt[i] + 1'b1;
      assign hit[i] = ch_en[i] && mode[i] == irq_filter_pkg::MODE_COUNTER && rise[i]
         && next_cnt == count_set_i[`CNT_W*i +: `CNT_W];

      always_ff @(posedge sys_clk_i or negedge rst_n) begin
         if (!rst_n) begin
            pulse_cnt[i] <= '0;
         end else if (!ch_en[i] || mode[i] != irq_filter_pkg::MODE_COUNTER) begin
            pulse_cnt[i] <= '0;
         end else if (hit[i]) begin
            pulse_cnt[i] <= '0;
         end else if (rise[i]) begin
            pulse_cnt[i] <= next_cnt;
         end
      end

      // A request raised in the cycle of its acknowledge must not be lost.
      always_ff @(posedge sys_clk_i or negedge rst_n) begin
         if (!rst_n) begin
            int_req_o[i] <= 1'b0;
         end else if (ch_en[i] && ((mode[i] == irq_filter_pkg::MODE_DIRECT && rise[i]) || hit[i])) begin
            int_req_o[i] <= 1'b1;
         end else if (int_ack_i[i] || !ch_en[i]) begin
            int_req_o[i] <= 1'b0;
         end
      end

      // Any synced high sample is caught, so pulses far under 0.2 ms latch too.
      always_ff @(posedge sys_clk_i or negedge rst_n) begin
         if (!rst_n) begin
            quick_latch[i] <= 1'b0;
         end else if (ch_en[i] && mode[i] == irq_filter_pkg::MODE_QUICK && in_sync[B]) begin
            quick_latch[i] <= 1'b1;
         end else if (quick_clr_i[i] || mode[i] != irq_filter_pkg::MODE_QUICK || !ch_en[i]) begin
            quick_latch[i] <= 1'b0;
         end
      end
   end

   // ============================================================
   // Input word image and output words
   logic [`N_IN-1:0] next_area;

   always_comb begin
      next_area = filt;
      for (int c = 0; c < `N_CH; c++) begin
         if (ch_en[c] && mode[c] == irq_filter_pkg::MODE_QUICK) begin
            next_area[`CH_BASE_BIT + c] = quick_latch[c];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         io_bit_area_o <= '0;
         out_pins_o <= '0;
      end else begin
         io_bit_area_o <= next_area;
         out_pins_o <= out_word_i;
      end
   end

   // ============================================================
   // Interval timer
   logic timer_expire;

   interval_timer u_timer (
      .clk(sys_clk_i),
      .rst_n(rst_n),
      .tk(tk),
      .start(timer_start_i),
      .stop(timer_stop_i),
      .mode(irq_filter_pkg::timer_mode_e'(timer_mode_i)),
      .period(timer_period_i),
      .expire(timer_expire),
      .running(timer_running_o)
   );

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         timer_int_o <= 1'b0;
      end else if (timer_expire) begin
         timer_int_o <= 1'b1;
      end else if (timer_ack_i) begin
         timer_int_o <= 1'b0;
      end
   end

   // ============================================================
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   a_tick_spacing: assert property (tk.tick |=> !tk.tick [*8])
      else $error("tick repeated too soon");
   a_direct_raise: assert property (ch_en[0] && mode[0] == irq_filter_pkg::MODE_DIRECT
      && $rose(in_sync[`CH_BASE_BIT]) |=> int_req_o[0])
      else $error("direct edge did not raise request");
   a_direct_latency: assert property ($rose(in_sync[`CH_BASE_BIT + 1]) && ch_en[1]
      && mode[1] == irq_filter_pkg::MODE_DIRECT
      |-> ##[1:2] int_req_o[1]) else $error("direct response too slow");
   a_counter_restart: assert property (hit[1] |=> pulse_cnt[1] == '0 && int_req_o[1])
      else $error("counter did not restart on hit");
   a_counter_equal: assert property (mode[1] == irq_filter_pkg::MODE_COUNTER && ch_en[1] && rise[1]
      && pulse_cnt[1] == count_set_i[2*`CNT_W-1:`CNT_W] - 1'b1 |=> int_req_o[1])
      else $error("set value reached without request");
   a_small_variant: assert property (variant_two_i |=> int_req_o[3:2] == 2'h0
      && io_bit_area_o[6:5] == $past(filt[6:5])) else $error("disabled channel active");
   a_plain_bit: assert property (mode[1] == irq_filter_pkg::MODE_PLAIN
      |=> io_bit_area_o[`CH_BASE_BIT + 1] == $past(filt[`CH_BASE_BIT + 1]))
      else $error("unused channel not filtered");
   a_quick_hold: assert property (quick_latch[2] && !quick_clr_i[2] && ch_en[2]
      && mode[2] == irq_filter_pkg::MODE_QUICK |=> quick_latch[2] && io_bit_area_o[`CH_BASE_BIT + 2])
      else $error("quick latch dropped before read");
   a_ack_set_wins: assert property (timer_expire && timer_ack_i |=> timer_int_o)
      else $error("timer expiry lost under acknowledge");
   a_filter_hold: assert property (!$stable(filt[0]) |-> $past(in_sync[0]) == filt[0])
      else $error("filter output not from stable input");

   c_direct_int: cover property (mode[0] == irq_filter_pkg::MODE_DIRECT && rise[0]);
   c_counter_hit: cover property (hit[1]);
   c_quick_pulse: cover property (quick_latch[2] ##1 quick_clr_i[2]);
   c_timer_twice: cover property (timer_expire ##[1:300] timer_expire);

endmodule

`default_nettype wire

// file: shared/irq_filter_defines.svh
/*
 * Timing counts, widths and limits for the input filter, interrupt inputs
 * and interval timer. Assumes the system clock runs at 10 MHz.
 */
`ifndef IRQ_FILTER_DEFINES_SVH
`define IRQ_FILTER_DEFINES_SVH

// ============================================================
// Clock and base tick
`define SYS_CLK_HZ 10000000
`define TICK_TIME_US 100
`define TICK_CYCLES (`SYS_CLK_HZ / 1000000 * `TICK_TIME_US)
`define TICK_CNT_W 10
`define TICKS_PER_MS 10

// ============================================================
// Input map: word 000 in bits 11..0, word 001 in bits 23..12
`define WORD_BITS 12
`define N_IN 24
`define N_OUT 16
`define N_CH 4
`define N_CH_SMALL 2
`define CH_BASE_BIT 3

// ============================================================
// Filter limits in 0.1 ms ticks for word 001 and later
`define FILT_CNT_W 11
`define FILT_W1_1MS 11'h002
`define FILT_W1_2MS 11'h00A
`define FILT_W1_4MS 11'h014
`define FILT_W1_8MS 11'h028
`define FILT_W1_16MS 11'h050
`define FILT_W1_32MS 11'h096
`define FILT_W1_64MS 11'h12C
`define FILT_W1_128MS 11'h258

// ============================================================
// Counter mode and interval timer, timer period in 0.1 ms units
`define CNT_W 16
`define TMR_W 22
`define TMR_MIN 22'h000005
`define TMR_MAX 22'h30D2C0

`endif

// file: shared/irq_filter_pkg.sv
/*
 * Types shared by the input filter and interrupt block.
 * Assumes the defines header is compiled with it.
 */
package irq_filter_pkg;

   // ============================================================
   // Use of each interrupt-capable terminal
   typedef enum logic [1:0] {
      MODE_PLAIN = 2'h0,
      MODE_DIRECT = 2'h1,
      MODE_COUNTER = 2'h2,
      MODE_QUICK = 2'h3
   } chan_mode_e;

   typedef enum logic {
      TMR_ONE_SHOT = 1'h0,
      TMR_SCHEDULED = 1'h1
   } timer_mode_e;

   typedef enum logic [1:0] {
      TS_IDLE = 2'h1,
      TS_RUN = 2'h2
   } timer_state_e;

endpackage

// file: shared/tick_if.sv
/*
 * Carries the 0.1 ms tick and filter setting from the top to its
 * submodules. Assumes all parties run on the one system clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface tick_if;
   logic tick;
   logic [2:0] filter_sel;

   modport src (output tick, output filter_sel);
   modport snk (input tick, input filter_sel);
endinterface

`default_nettype wire

// file: rtl/input_debounce.sv
/*
 * Debounce filter for every external input bit.
 * Assumes inputs are already synchronised and the tick is one cycle wide.
 */
`include "irq_filter_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module input_debounce (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Tick and setting
   tick_if.snk tk,
   // Data
   input wire logic [`N_IN-1:0] raw,
   output logic [`N_IN-1:0] filt
);

   function automatic logic [`FILT_CNT_W-1:0] w1_limit(input logic [2:0] sel);
      logic [`FILT_CNT_W-1:0] v;
      v = `FILT_W1_1MS;
      unique case (sel)
         3'h0: v = `FILT_W1_1MS;
         3'h1: v = `FILT_W1_2MS;
         3'h2: v = `FILT_W1_4MS;
         3'h3: v = `FILT_W1_8MS;
         3'h4: v = `FILT_W1_16MS;
         3'h5: v = `FILT_W1_32MS;
         3'h6: v = `FILT_W1_64MS;
         3'h7: v = `FILT_W1_128MS;
      endcase
      return v;
   endfunction

   logic [`FILT_CNT_W-1:0] lim_w0;
   logic [`FILT_CNT_W-1:0] lim_w1;

   assign lim_w0 = `FILT_CNT_W'(`TICKS_PER_MS) << tk.filter_sel;
   assign lim_w1 = w1_limit(tk.filter_sel);

   // ============================================================
   // Per-bit stability counters
   for (genvar b = 0; b < `N_IN; b++) begin : g_bit
      logic [`FILT_CNT_W-1:0] stable_cnt;
      logic [`FILT_CNT_W-1:0] lim;
      assign lim = (b < `WORD_BITS) ? lim_w0 : lim_w1;

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            stable_cnt <= '0;
            filt[b] <= 1'b0;
         end else if (raw[b] == filt[b]) begin
            stable_cnt <= '0;
         end else if (tk.tick) begin
            // The first tick can fall at once, so one extra tick keeps the delay at or above the limit.
            if (stable_cnt >= lim) begin
               filt[b] <= raw[b];
               stable_cnt <= '0;
            end else begin
               stable_cnt <= stable_cnt + 1'b1;
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: rtl/interval_timer.sv
/*
 * Interval timer with one-shot and scheduled modes.
 * Assumes a one-cycle tick every 0.1 ms and same-clock control pulses.
 */
`include "irq_filter_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module interval_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   tick_if.snk tk,
   // Control
   input wire logic start,
   input wire logic stop,
   input wire irq_filter_pkg::timer_mode_e mode,
   input wire logic [`TMR_W-1:0] period,
   // Status
   output logic expire,
   output logic running
);

   irq_filter_pkg::timer_state_e state;
   logic [`TMR_W-1:0] remain;
   logic [`TMR_W-1:0] load;

   // clamp to the legal period range
   assign load = (period < `TMR_MIN) ? `TMR_MIN : (period > `TMR_MAX) ? `TMR_MAX : period;
   assign running = (state == irq_filter_pkg::TS_RUN);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= irq_filter_pkg::TS_IDLE;
         remain <= '0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         unique case (state)
            irq_filter_pkg::TS_IDLE: begin
               if (start) begin
                  remain <= load;
                  state <= irq_filter_pkg::TS_RUN;
               end
            end
            irq_filter_pkg::TS_RUN: begin
               if (stop) begin
                  state <= irq_filter_pkg::TS_IDLE;
               end else if (start) begin
                  remain <= load;
               end else if (tk.tick) begin
                  if (remain == `TMR_W'(1)) begin
                     expire <= 1'b1;
                     remain <= load;
                     if (mode == irq_filter_pkg::TMR_ONE_SHOT) begin
                        state <= irq_filter_pkg::TS_IDLE;
                     end
                  end else begin
                     remain <= remain - 1'b1;
                  end
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_oneshot_stops: assert property (expire && mode == irq_filter_pkg::TMR_ONE_SHOT && !start
      |-> !running) else $error("one-shot timer kept running");
   a_sched_reload: assert property (running && tk.tick && !stop && !start && remain == `TMR_W'(1)
      && mode == irq_filter_pkg::TMR_SCHEDULED |=> running && expire && remain == $past(load))
      else $error("scheduled timer did not reload");

endmodule

`default_nettype wire

// file: tb/field_core_model.sv
/*
 * Model of the field pins and of the program core that answers requests.
 * Assumes the bench calls its tasks and that everything runs on clk_i.
 */
`timescale 1ns/1ns
`default_nettype none

module field_core_model (
   // Clock
   input wire logic clk_i,
   // Field pins
   output logic [23:0] field_o,
   // Core answers
   output logic [3:0] int_ack_o,
   output logic [3:0] quick_clr_o,
   output logic timer_ack_o
);
   // ============================================================
   // Answer strobes
   // Strobes 0..3 acknowledge channels, 4..7 clear latches, 8 the timer.
   logic [8:0] strb = 9'h000;

   initial begin
      field_o = 24'h000000;
   end

   assign int_ack_o = strb[3:0];
   assign quick_clr_o = strb[7:4];
   assign timer_ack_o = strb[8];

   task automatic set_pin(input int b, input logic v);
      @(posedge clk_i);
      field_o[b] <= v;
   endtask

   // short pulse
   // Pulses far shorter than a scan are what the latch exists for.
   task automatic pulse(input int b, input int w);
      set_pin(b, 1'b1);
      repeat (w) @(posedge clk_i);
      field_o[b] <= 1'b0;
   endtask

   task automatic strobe(input int s);
      @(posedge clk_i);
      strb[s] <= 1'b1;
      @(posedge clk_i);
      strb[s] <= 1'b0;
   endtask
endmodule

`default_nettype wire

// file: tb/testbench.sv
/*
 * Self-checking bench for the input filter and interrupt block.
 * Assumes the defines header is on the include path.
 */
`timescale 1ns/1ns
`default_nettype none
`include "irq_filter_defines.svh"

module testbench;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [`N_OUT-1:0] out_word_i = 16'h0000;
   logic variant_two_i = 1'b0;
   logic [2:0] filter_sel_i = 3'h0;
   logic [7:0] chan_mode_i = 8'h00;
   logic [63:0] count_set_i = 64'h0;
   logic timer_start_i = 1'b0;
   logic timer_stop_i = 1'b0;
   logic timer_mode_i = 1'b0;
   logic [`TMR_W-1:0] timer_period_i = 22'h000005;
   logic [`N_IN-1:0] field, io_bit_area_o;
   logic [`N_OUT-1:0] out_pins_o;
   logic [3:0] int_req_o, int_ack, quick_clr;
   logic timer_int_o, timer_running_o, timer_ack;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;
   int seed = 80534;
   int model_cnt, setv, gap;
   logic exp;

   // ============================================================
   // Clock, timeout and parts
   always #50 sys_clk_i = ~sys_clk_i;

   // The run needs about 55000 cycles, so this ceiling means a hang.
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_mismatch++;
         test_done();
      end
   end

   input_filter_interrupt_timer input_filter_interrupt_timer_i (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .field_in_i(field),
      .out_word_i(out_word_i), .io_bit_area_o(io_bit_area_o),
      .out_pins_o(out_pins_o), .variant_two_i(variant_two_i),
      .filter_sel_i(filter_sel_i), .chan_mode_i(chan_mode_i),
      .count_set_i(count_set_i), .int_req_o(int_req_o), .int_ack_i(int_ack),
      .quick_clr_i(quick_clr), .timer_start_i(timer_start_i),
      .timer_stop_i(timer_stop_i), .timer_mode_i(timer_mode_i),
      .timer_period_i(timer_period_i), .timer_ack_i(timer_ack),
      .timer_int_o(timer_int_o), .timer_running_o(timer_running_o));

   field_core_model field_core_model_i (.clk_i(sys_clk_i), .field_o(field),
      .int_ack_o(int_ack), .quick_clr_o(quick_clr), .timer_ack_o(timer_ack));

   // ============================================================
   // Helpers
   function automatic int lfsr(input int x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask

   task automatic tk(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic wait_timer(output int n);
      n = 0;
      #1;
      while (timer_int_o !== 1'b1 && n < 8000) begin
         tk(1);
         n++;
      end
   endtask

   task automatic timer_go(input logic m, input logic [21:0] p);
      @(posedge sys_clk_i);
      timer_mode_i <= m;
      timer_period_i <= p;
      timer_start_i <= 1'b1;
      @(posedge sys_clk_i);
      timer_start_i <= 1'b0;
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ============================================================
   // Scenarios
   initial begin
      tk(5);
      check(int_req_o, 4'h0);
      tk(5);
      @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      tk(3);
      repeat (4) begin
         seed = lfsr(seed);
         @(posedge sys_clk_i);
         out_word_i <= seed[15:0];
         tk(1);
         check(out_pins_o, seed[15:0]);
      end
      $display("test output map done");
      field_core_model_i.set_pin(0, 1'b1);
      field_core_model_i.set_pin(12, 1'b1);
      field_core_model_i.set_pin(6, 1'b1);
      tk(1900);
      check(io_bit_area_o[12], 1'b0);
      tk(1200);
      check(io_bit_area_o[12], 1'b1);
      check(io_bit_area_o[0], 1'b0);
      tk(6800);
      check({io_bit_area_o[6], io_bit_area_o[0]}, 2'h0);
      tk(1200);
      check({io_bit_area_o[6], io_bit_area_o[0]}, 2'h3);
      $display("test filter done");
      @(posedge sys_clk_i);
      chan_mode_i <= 8'h01;
      filter_sel_i <= seed[2:0];
      field_core_model_i.set_pin(3, 1'b1);
      tk(2);
      check(int_req_o[0], 1'b0);
      tk(1);
      check(int_req_o[0], 1'b1);
      field_core_model_i.strobe(0);
      tk(1);
      check(int_req_o[0], 1'b0);
      field_core_model_i.set_pin(3, 1'b0);
      $display("test direct done");
      seed = lfsr(seed);
      setv = 2 + (seed[7:0] % 3);
      model_cnt = 0;
      @(posedge sys_clk_i);
      chan_mode_i <= 8'h09;
      count_set_i <= 64'(setv) << 16;
      for (int k = 0; k < 2 * setv + 1; k++) begin
         field_core_model_i.pulse(4, 3);
         tk(3);
         model_cnt++;
         exp = (model_cnt == setv);
         if (exp) model_cnt = 0;
         check(int_req_o[1], exp);
         if (exp) field_core_model_i.strobe(1);
      end
      $display("test counter done");
      @(posedge sys_clk_i);
      chan_mode_i <= 8'h30;
      field_core_model_i.pulse(5, 3);
      tk(8);
      check(io_bit_area_o[5], 1'b1);
      tk(500);
      check({int_req_o[2], io_bit_area_o[5]}, 2'h1);
      field_core_model_i.strobe(6);
      tk(3);
      check(io_bit_area_o[5], 1'b0);
      $display("test quick done");
      @(posedge sys_clk_i);
      variant_two_i <= 1'b1;
      chan_mode_i <= 8'h15;
      field_core_model_i.pulse(5, 3);
      field_core_model_i.pulse(4, 3);
      field_core_model_i.pulse(3, 3);
      tk(3);
      check(int_req_o, 4'h3);
      field_core_model_i.strobe(0);
      field_core_model_i.strobe(1);
      @(posedge sys_clk_i);
      variant_two_i <= 1'b0;
      $display("test variant done");
      timer_go(1'b0, 22'h000005);
      wait_timer(gap);
      check(gap >= 3900 && gap <= 5100, 1'b1);
      field_core_model_i.strobe(8);
      tk(12000);
      check({timer_running_o, timer_int_o}, 2'h0);
      $display("test one-shot done");
      seed = lfsr(seed);
      setv = 4 + seed[1:0];
      timer_go(1'b1, 22'(setv));
      wait_timer(gap);
      repeat (2) begin
         field_core_model_i.strobe(8);
         wait_timer(gap);
         check(gap + 2, (setv < 5 ? 5 : setv) * 1000);
      end
      check(timer_running_o, 1'b1);
      field_core_model_i.strobe(8);
      @(posedge sys_clk_i);
      timer_stop_i <= 1'b1;
      @(posedge sys_clk_i);
      timer_stop_i <= 1'b0;
      tk(6000);
      check({timer_running_o, timer_int_o}, 2'h0);
      $display("test scheduled done");
      test_done();
   end
endmodule

`default_nettype wire
